// File: verification/tdct_clk_src.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_clk_src #(
    parameter int unsigned HALF = 2
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // burst request
    input  wire logic        start_in,
    input  wire logic [15:0] num_in,
    // counter clock pin
    output logic             ctr_clk_out,
    output logic             busy_out
);
    logic [15:0] left_q;
    logic [7:0]  ph_q;

    assign busy_out = (left_q != 16'h0000);

    // the clock stands low between bursts, one rise per counted tick
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            left_q      <= 16'h0000;
            ph_q        <= 8'h00;
            ctr_clk_out <= 1'b0;
        end else if (start_in) begin
            left_q <= num_in;
            ph_q   <= 8'h00;
        end else if (busy_out) begin
            if (ph_q == 8'(HALF - 1)) begin
                ph_q        <= 8'h00;
                ctr_clk_out <= ~ctr_clk_out;
                if (ctr_clk_out) left_q <= left_q - 16'h0001;
            end else begin
                ph_q <= ph_q + 8'h01;
            end
        end
    end
endmodule : tdct_clk_src

`default_nettype wire

// File: verification/tdct_top_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_top_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  gate = 3'h0;
    logic [2:0]  start = 3'h0;
    logic [15:0] num [3] = '{3{16'h0000}};
    logic [1:0]  sel = 2'h0;
    logic [2:0]  mode = 3'h0;
    logic [15:0] cnt = 16'h0000;
    logic        cfg = 1'b0, rel = 1'b0, hlt = 1'b0, rd = 1'b0;
    logic        fmt = 1'b0, lvl = 1'b0;
    wire  [2:0]  tclk, busy, q_out;
    wire  [15:0] rdata;
    wire         rvalid, serr;
    logic [15:0] exp_q [$];
    logic [31:0] lfsr = 32'h0000c5a6;
    logic [15:0] rv [3];
    int          error_cnt = 0, total_checks = 0, cyc = 0, nerr = 0, lc;
    // kind, mode, count, low cycles, high cycles at four cycles a tick
    int tm [4][5] = '{'{0, 2, 4, 4, 12}, '{1, 3, 5, 4, 16},
                      '{0, 3, 4, 8, 8}, '{0, 3, 5, 8, 12}};

    always #10 clk = ~clk;

    tdct_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .ctr_clk_in(tclk),
        .gate_in(gate), .ctr_sel_in(sel), .counter_configure_in(cfg),
        .counter_reload_write_in(rel), .counter_halt_force_in(hlt),
        .counter_live_read_in(rd), .mode_in(mode),
        .count_format_sel_in(fmt), .count_in(cnt), .halt_level_in(lvl),
        .ctr_out(q_out), .read_data_out(rdata), .read_valid_out(rvalid),
        .sel_error_out(serr));

    for (genvar i = 0; i < 3; i++) begin : g_src
        tdct_clk_src u_src (.core_clk_in(clk), .rst_n_in(rst_n),
            .start_in(start[i]), .num_in(num[i]), .ctr_clk_out(tclk[i]),
            .busy_out(busy[i]));
    end

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt

    // every task that waits starts and ends one nanosecond after a rising edge
    task automatic cmd(input int k, input logic [1:0] s, input logic [2:0] m,
                       input logic f, input logic [15:0] c, input logic l);
        sel = s;
        mode = m;
        fmt = f;
        cnt = c;
        lvl = l;
        {cfg, rel, hlt, rd} = 4'b1000 >> k;
        wt(1);
        {cfg, rel, hlt, rd} = 4'h0;
    endtask : cmd

    task automatic rdc(input logic [1:0] s, input logic [15:0] e);
        exp_q.push_back(e);
        cmd(3, s, 3'h0, 1'b0, 16'h0000, 1'b0);
        wt(3);
    endtask : rdc

    task automatic go(input int i, input logic [15:0] n);
        start[i] = 1'b1;
        num[i] = n;
        wt(1);
        start[i] = 1'b0;
    endtask : go

    task automatic ticks(input int i, input logic [15:0] n);
        go(i, n);
        while (busy[i]) wt(1);
        wt(4);
    endtask : ticks

    task automatic run(input int i, input logic v, output int n);
        n = 0;
        while (q_out[i] === v && n < 300) begin
            wt(1);
            n++;
        end
    endtask : run

    // skips the phase in progress so a whole period is measured
    task automatic meas(input int i, input int lo, input int hi);
        int n;
        // one extra period is skipped: a reload-written count lands only at a reload
        run(i, 1'b0, n);
        run(i, 1'b1, n);
        run(i, 1'b0, n);
        run(i, 1'b1, n);
        run(i, 1'b0, n);
        chk(16'(n), 16'(lo));
        run(i, 1'b1, n);
        chk(16'(n), 16'(hi));
    endtask : meas

    task automatic sweep(input int i, input int n, output int l);
        go(i, 16'(n));
        l = 0;
        repeat (n * 4 + 8) begin
            wt(1);
            if (q_out[i] === 1'b0) l++;
        end
    endtask : sweep

    always @(posedge clk) begin
        cyc++;
        if (serr === 1'b1) nerr++;
        if (rvalid === 1'b1 && exp_q.size() > 0) begin
            chk(rdata, exp_q.pop_front());
        end else if (rst_n && rvalid !== 1'b0) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: unexpected read", $time);
        end
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        #1;
        chk({13'h0000, q_out}, 16'h0007);
        rst_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            lfsr = nxt(lfsr);
            rv[i] = lfsr[15:0];
            cmd(0, 2'(i), 3'h0, 1'b0, rv[i], 1'b0);
            rdc(2'(i), rv[i]);
        end
        cmd(3, 2'h3, 3'h0, 1'b0, 16'h0000, 1'b0);
        wt(3);
        chk(16'(nerr), 16'h0001);
        $display("load test done");
        gate[0] = 1'b1;
        cmd(0, 2'h0, 3'h0, 1'b0, 16'h0003, 1'b0);
        ticks(0, 2);
        rdc(2'h0, 16'h0001);
        rdc(2'h0, 16'h0001);
        chk({15'h0000, q_out[0]}, 16'h0000);
        ticks(0, 1);
        chk({15'h0000, q_out[0]}, 16'h0001);
        rdc(2'h1, rv[1]);
        gate[1] = 1'b1;
        cmd(0, 2'h1, 3'h0, 1'b1, 16'h0100, 1'b0);
        ticks(1, 1);
        rdc(2'h1, 16'h0099);
        cmd(0, 2'h1, 3'h0, 1'b1, 16'h1fa9, 1'b0);
        rdc(2'h1, 16'h1999);
        $display("toggle and format test done");
        go(0, 16'd1000);
        for (int r = 0; r < 4; r++) begin
            cmd(tm[r][0], 2'h0, 3'(tm[r][1]), 1'b0, 16'(tm[r][2]), 1'b0);
            meas(0, tm[r][3], tm[r][4]);
        end
        for (int v = 0; v < 2; v++) begin
            cmd(2, 2'h0, 3'h0, 1'b0, 16'h0000, 1'(v));
            wt(20);
            chk({15'h0000, q_out[0]}, 16'(v));
        end
        $display("periodic and halt test done");
        gate[2] = 1'b1;
        cmd(0, 2'h2, 3'h4, 1'b0, 16'h0003, 1'b0);
        sweep(2, 6, lc);
        chk(16'(lc), 16'h0004);
        gate[2] = 1'b0;
        cmd(0, 2'h2, 3'h5, 1'b0, 16'h0003, 1'b0);
        sweep(2, 6, lc);
        chk(16'(lc), 16'h0000);
        rdc(2'h2, 16'h0003);
        gate[2] = 1'b1;
        sweep(2, 6, lc);
        chk(16'(lc), 16'h0004);
        gate[2] = 1'b0;
        cmd(0, 2'h2, 3'h1, 1'b0, 16'h0003, 1'b0);
        wt(2);
        gate[2] = 1'b1;
        wt(5);
        chk({15'h0000, q_out[2]}, 16'h0000);
        ticks(2, 4);
        chk({15'h0000, q_out[2]}, 16'h0001);
        chk(16'(exp_q.size()), 16'h0000);
        $display("strobe test done");
        results();
    end
endmodule : tdct_top_bench

`default_nettype wire

// File: verification/tdct_top_chk.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_top_chk #(
    parameter int unsigned NUM = 3
) (
    // clock, reset, pins
    input wire logic           core_clk_in,
    input wire logic           rst_n_in,
    input wire logic [NUM-1:0] ctr_clk_in,
    input wire logic [NUM-1:0] gate_in,
    // commands
    input wire logic [1:0]     ctr_sel_in,
    input wire logic           counter_configure_in,
    input wire logic           counter_reload_write_in,
    input wire logic           counter_halt_force_in,
    input wire logic           counter_live_read_in,
    input wire logic [2:0]     mode_in,
    input wire logic           count_format_sel_in,
    input wire logic [15:0]    count_in,
    input wire logic           halt_level_in,
    // results
    input wire logic [NUM-1:0] ctr_out,
    input wire logic [15:0]    read_data_out,
    input wire logic           read_valid_out,
    input wire logic           sel_error_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic ok_sel;
    logic cmd;
    logic cfg;
    assign ok_sel = (ctr_sel_in != 2'h3);
    assign cmd = counter_configure_in | counter_reload_write_in
               | counter_halt_force_in | counter_live_read_in;
    // halt outranks configure, so a joint request is not a configure
    assign cfg = counter_configure_in & ~counter_halt_force_in & ok_sel;

    a_read_latency: assert property (
        counter_live_read_in && ok_sel |-> ##2 read_valid_out)
        else $error("read not answered in two cycles");
    a_read_cause: assert property (
        read_valid_out |-> $past(counter_live_read_in, 2))
        else $error("read data without a read");
    a_read_hold: assert property (
        !read_valid_out |-> $stable(read_data_out))
        else $error("read data moved without a read");
    a_sel_error: assert property (
        cmd && !ok_sel |-> ##[1:2] sel_error_out)
        else $error("bad counter number not flagged");
    a_sel_refused: assert property (
        counter_live_read_in && !ok_sel |-> ##2 !read_valid_out)
        else $error("bad counter number answered");
    a_halt_level: assert property (
        counter_halt_force_in && ok_sel |-> ##2
        ctr_out[$past(ctr_sel_in, 2)] == $past(halt_level_in, 2))
        else $error("halt level not driven");
    a_toggle_low: assert property (
        cfg && mode_in == 3'h0 |-> ##2 !ctr_out[$past(ctr_sel_in, 2)])
        else $error("toggle mode output not low");
    a_strobe_high: assert property (
        cfg && mode_in == 3'h4 |-> ##2 ctr_out[$past(ctr_sel_in, 2)])
        else $error("strobe mode output not high");

    c_read: cover property (read_valid_out);
    c_error: cover property (sel_error_out);
    c_halt: cover property (counter_halt_force_in && ok_sel);
endmodule : tdct_top_chk

bind tdct_top tdct_top_chk #(.NUM(NUM)) u_chk (
    .core_clk_in, .rst_n_in, .ctr_clk_in, .gate_in, .ctr_sel_in,
    .counter_configure_in, .counter_reload_write_in,
    .counter_halt_force_in, .counter_live_read_in, .mode_in,
    .count_format_sel_in, .count_in, .halt_level_in, .ctr_out,
    .read_data_out, .read_valid_out, .sel_error_out);

`default_nettype wire

// File: verilog/tdct_channel.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_channel (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // counter pins, sampled in the core clock
    input  wire logic        ctr_clk_in,
    input  wire logic        gate_in,
    // commands for this counter
    input  wire logic        configure_in,
    input  wire logic        reload_write_in,
    input  wire logic        halt_force_in,
    input  wire logic [2:0]  mode_in,
    input  wire logic        format_in,
    input  wire logic [15:0] count_in,
    input  wire logic        halt_level_in,
    // results
    output logic             ctr_out,
    output logic [15:0]      count_out
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // bcd decrement with a borrow per decade; 0000 wraps to 9999
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcd_dec

    // clamp a bcd load into 0..9999 by clamping each digit to nine
    function automatic logic [15:0] bcd_clamp(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        for (int i = 0; i < 4; i++) begin
            if (r[i*4 +: 4] > 4'h9) begin
                r[i*4 +: 4] = 4'h9;
            end
        end
        return r;
    endfunction : bcd_clamp

    // ****************************************************************
    // state
    // ****************************************************************
    tdct_pkg::tdct_mode_e  mode_q;
    tdct_pkg::tdct_state_e st_q;
    logic                  fmt_q;
    logic [15:0]           init_q;
    logic [15:0]           cnt_q;
    logic                  out_q;
    logic                  clk_prev_q;
    logic                  gate_prev_q;
    logic                  half_q;
    logic                  tick;
    logic                  gate_rise;
    logic [15:0]           load_val;
    logic [15:0]           dec_val;
    logic [15:0]           half_val;
    logic                  at_one;

    assign tick      = ctr_clk_in & ~clk_prev_q;
    assign gate_rise = gate_in & ~gate_prev_q;
    assign load_val  = (format_in == tdct_pkg::FMT_BCD) ?
                       bcd_clamp(count_in) : count_in;
    assign dec_val   = (fmt_q == tdct_pkg::FMT_BCD) ?
                       bcd_dec(cnt_q) : cnt_q - 16'h0001;
    // square wave: each half counts init/2 ticks, later high halves one more for odd init (binary halves only)
    assign half_val  = {1'b0, init_q[15:1]};
    assign at_one    = (cnt_q == 16'h0001) || (cnt_q == 16'h0000);

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            clk_prev_q  <= 1'b0;
            gate_prev_q <= 1'b0;
        end else begin
            clk_prev_q  <= ctr_clk_in;
            gate_prev_q <= gate_in;
        end
    end

    // ****************************************************************
    // configuration and sequencing
    // ****************************************************************
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            mode_q <= tdct_pkg::MODE_TOGGLE;
            fmt_q  <= tdct_pkg::FMT_BIN;
            init_q <= tdct_pkg::RESET_CNT;
            cnt_q  <= tdct_pkg::RESET_CNT;
            st_q   <= tdct_pkg::ST_HALTED;
            out_q  <= 1'b1;
            half_q <= 1'b0;
        end else if (halt_force_in) begin
            st_q  <= tdct_pkg::ST_HALTED;
            out_q <= halt_level_in;
        end else if (configure_in) begin
            // unused codes run as the software strobe, never stall
            mode_q <= (mode_in > 3'h5) ?
                      tdct_pkg::MODE_SOFTWARE_STROBE :
                      tdct_pkg::tdct_mode_e'(mode_in);
            fmt_q  <= format_in;
            init_q <= load_val;
            cnt_q  <= load_val;
            half_q <= 1'b0;
            case (tdct_pkg::tdct_mode_e'(mode_in))
                tdct_pkg::MODE_TOGGLE: begin
                    out_q <= 1'b0;
                    st_q  <= tdct_pkg::ST_RUN;
                end
                tdct_pkg::MODE_GATED_SINGLE,
                tdct_pkg::MODE_GATE_STROBE: begin
                    out_q <= 1'b1;
                    st_q  <= tdct_pkg::ST_WAIT;
                end
                tdct_pkg::MODE_SQUARE_WAVE: begin
                    out_q <= 1'b1;
                    cnt_q <= {1'b0, load_val[15:1]};
                    st_q  <= tdct_pkg::ST_RUN;
                end
                default: begin
                    out_q <= 1'b1;
                    st_q  <= tdct_pkg::ST_RUN;
                end
            endcase
        end else begin
            if (reload_write_in) begin
                init_q <= (fmt_q == tdct_pkg::FMT_BCD) ?
                          bcd_clamp(count_in) : count_in;
            end
            case (st_q)
                tdct_pkg::ST_WAIT: begin
                    if (gate_rise) begin
                        cnt_q <= init_q;
                        st_q  <= tdct_pkg::ST_RUN;
                        if (mode_q == tdct_pkg::MODE_GATED_SINGLE) begin
                            out_q <= 1'b0;
                        end
                    end
                end
                tdct_pkg::ST_RUN: begin
                    case (mode_q)
                        tdct_pkg::MODE_TOGGLE,
                        tdct_pkg::MODE_SOFTWARE_STROBE: begin
                            if (tick && gate_in) begin
                                cnt_q <= dec_val;
                                if (at_one) begin
                                    out_q <= (mode_q == tdct_pkg::MODE_TOGGLE);
                                    st_q  <= tdct_pkg::ST_DONE;
                                end
                            end
                        end
                        tdct_pkg::MODE_GATED_SINGLE,
                        tdct_pkg::MODE_GATE_STROBE: begin
                            if (tick) begin
                                cnt_q <= dec_val;
                                if (at_one) begin
                                    out_q <= (mode_q ==
                                        tdct_pkg::MODE_GATED_SINGLE);
                                    st_q  <= tdct_pkg::ST_DONE;
                                end
                            end
                        end
                        tdct_pkg::MODE_RATE: begin
                            if (tick) begin
                                if (at_one) begin
                                    cnt_q <= init_q;
                                    out_q <= 1'b0;
                                end else begin
                                    cnt_q <= dec_val;
                                    out_q <= 1'b1;
                                end
                            end
                        end
                        tdct_pkg::MODE_SQUARE_WAVE: begin
                            if (tick) begin
                                if (at_one) begin
                                    // odd counts give the high half one more
                                    cnt_q  <= half_q ?
                                              (half_val + {15'h0, init_q[0]})
                                              : half_val;
                                    half_q <= ~half_q;
                                    out_q  <= half_q;
                                end else begin
                                    cnt_q <= dec_val;
                                end
                            end
                        end
                        default: begin
                            st_q <= tdct_pkg::ST_HALTED;
                        end
                    endcase
                end
                tdct_pkg::ST_DONE: begin
                    // strobes stay low for exactly one counter clock
                    if (tick && mode_q != tdct_pkg::MODE_TOGGLE &&
                        mode_q != tdct_pkg::MODE_GATED_SINGLE) begin
                        out_q <= 1'b1;
                        if (mode_q == tdct_pkg::MODE_GATE_STROBE) begin
                            st_q <= tdct_pkg::ST_WAIT;
                        end
                    end else if (mode_q == tdct_pkg::MODE_GATED_SINGLE) begin
                        st_q <= tdct_pkg::ST_WAIT;
                    end
                end
                default: begin
                    st_q <= st_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ctr_out   <= 1'b1;
            count_out <= tdct_pkg::RESET_CNT;
        end else begin
            ctr_out   <= out_q;
            count_out <= cnt_q;
        end
    end

endmodule : tdct_channel

`default_nettype wire

// File: verilog/tdct_pkg.sv
package tdct_pkg;

    // ****************************************************************
    // counter bank
    // ****************************************************************
    localparam int unsigned NUM_CTRS  = 3;
    localparam int unsigned CTR_W     = 16;
    localparam int unsigned SEL_W     = 2;

    // ****************************************************************
    // output modes
    // ****************************************************************
    typedef enum logic [2:0] {
        MODE_TOGGLE           = 3'b000,
        MODE_GATED_SINGLE     = 3'b001,
        MODE_RATE             = 3'b010,
        MODE_SQUARE_WAVE      = 3'b011,
        MODE_SOFTWARE_STROBE  = 3'b100,
        MODE_GATE_STROBE      = 3'b101
    } tdct_mode_e;

    // ****************************************************************
    // count format and limits
    // ****************************************************************
    localparam logic       FMT_BIN     = 1'b0;
    localparam logic       FMT_BCD     = 1'b1;
    localparam logic [15:0] BCD_MAX    = 16'h9999;
    localparam logic [15:0] RESET_CNT  = 16'h0000;

    // ****************************************************************
    // per-counter run states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_HALTED  = 2'b00,
        ST_WAIT    = 2'b01,
        ST_RUN     = 2'b10,
        ST_DONE    = 2'b11
    } tdct_state_e;

endpackage : tdct_pkg

// File: verilog/tdct_top.sv
`timescale 1ns/1ps
`default_nettype none

module tdct_top #(
    parameter int unsigned NUM = tdct_pkg::NUM_CTRS
) (
    // clock and reset
    input  wire logic           core_clk_in,
    input  wire logic           rst_n_in,
    // counter pins
    input  wire logic [NUM-1:0] ctr_clk_in,
    input  wire logic [NUM-1:0] gate_in,
    // commands
    input  wire logic [1:0]     ctr_sel_in,
    input  wire logic           counter_configure_in,
    input  wire logic           counter_reload_write_in,
    input  wire logic           counter_halt_force_in,
    input  wire logic           counter_live_read_in,
    input  wire logic [2:0]     mode_in,
    input  wire logic           count_format_sel_in,
    input  wire logic [15:0]    count_in,
    input  wire logic           halt_level_in,
    // results
    output logic [NUM-1:0]      ctr_out,
    output logic [15:0]         read_data_out,
    output logic                read_valid_out,
    output logic                sel_error_out
);

    // ****************************************************************
    // per-counter instances
    // ****************************************************************
    logic [15:0] cnt_w [NUM];
    logic        sel_ok;
    logic        rd_pend_q;
    logic [1:0]  rd_sel_q;

    assign sel_ok = (32'(ctr_sel_in) < NUM);

    for (genvar g = 0; g < NUM; g++) begin : g_ctr
        logic hit;
        assign hit = sel_ok && (32'(ctr_sel_in) == g);
        tdct_channel u_ch (
            .core_clk_in     (core_clk_in),
            .rst_n_in        (rst_n_in),
            .ctr_clk_in      (ctr_clk_in[g]),
            .gate_in         (gate_in[g]),
            .configure_in    (hit & counter_configure_in),
            .reload_write_in (hit & counter_reload_write_in),
            .halt_force_in   (hit & counter_halt_force_in),
            .mode_in         (mode_in),
            .format_in       (count_format_sel_in),
            .count_in        (count_in),
            .halt_level_in   (halt_level_in),
            .ctr_out         (ctr_out[g]),
            .count_out       (cnt_w[g])
        );
    end

    // ****************************************************************
    // live read; a bad counter number is flagged, not acted on
    // ****************************************************************
    // the channel's count flop lags one cycle, so the read waits one stage
    // and then returns the count as it stood at the read edge
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rd_pend_q      <= 1'b0;
            rd_sel_q       <= 2'h0;
            read_data_out  <= 16'h0000;
            read_valid_out <= 1'b0;
            sel_error_out  <= 1'b0;
        end else begin
            rd_pend_q      <= counter_live_read_in & sel_ok;
            rd_sel_q       <= ctr_sel_in;
            read_valid_out <= rd_pend_q;
            sel_error_out  <= ~sel_ok & (counter_live_read_in |
                              counter_configure_in |
                              counter_reload_write_in |
                              counter_halt_force_in);
            if (rd_pend_q) begin
                read_data_out <= cnt_w[rd_sel_q];
            end
        end
    end

endmodule : tdct_top

`default_nettype wire
